// ===== sslp_pkg.sv
// Purpose: Shared constants for the synthesizer serial load port.
// Assumes: Word layout is 24 bits, select code in the two lowest bits.
// Notes:   Power-down and monitor field positions sit in the control latch.
package sslp_pkg;
    localparam int WORD_W = 24;
    localparam logic [1:0] SEL_CONTROL  = 2'h0;
    localparam logic [1:0] SEL_REFDIV   = 2'h1;
    localparam logic [1:0] SEL_FBDIV    = 2'h2;
    localparam logic [1:0] SEL_TEST     = 2'h3;
    localparam int PD1_BIT              = 20;
    localparam int PD2_BIT              = 21;
    localparam int MON_LSB              = 5;
    localparam int RST_VALUE            = 0;
    localparam logic [23:0] LATCH_RESET = 24'h000000;
    localparam logic [2:0] MON_LOCK     = 3'h1;
    localparam logic [2:0] MON_RFDIV    = 3'h2;
    localparam logic [2:0] MON_REFDIV   = 3'h4;
endpackage

// ===== sslp_port.sv
// Purpose: Serial programming port with chip-enable and monitor selection.
// Assumes: Serial clock, data, strobe and enable are asynchronous pins.
// Notes:   Pins are sampled by the system clock, so a latch updates three clocks after the
//          strobe pin rises and the power state follows the enable pin by three clocks.
// Operation
// - Each rising serial clock edge shifts the data level into the 24-bit register.
// - The two lowest word bits pick the destination latch and are not payload.
// - A rising load strobe copies the shift register into exactly one latch.
// - The latch is picked by the select bits present at the load moment.
// - A low chip enable keeps the device powered down regardless of settings.
// - A low chip enable puts the charge pump output into high impedance.
// - A high chip enable powers up only if the stored power-down bits allow it.
// - The monitor output carries lock detect, divided feedback or divided reference.
// - On power-down the series reference switch opens and the shunt closes.
// - Select 00 is control, 01 reference divider, 10 feedback divider, 11 test.
`timescale 1ns/10ps
module sslp_port
    import sslp_pkg::*;
#(
    parameter int W = WORD_W
)
(
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         serial_clock_i,
    input  wire logic         serial_data_i,
    input  wire logic         load_strobe_i,
    input  wire logic         chip_enable_i,
    input  wire logic         lock_detect_i,
    input  wire logic         rf_divided_i,
    input  wire logic         ref_divided_i,
    output logic [W-1:0]      control_latch_o,
    output logic [W-1:0]      refdiv_latch_o,
    output logic [W-1:0]      fbdiv_latch_o,
    output logic [W-1:0]      test_latch_o,
    output logic              powered_down_o,
    output logic              charge_pump_output_oe_o,
    output logic              ref_series_switch_closed_o,
    output logic              ref_shunt_switch_o,
    output logic              monitor_output_o
);
    logic [3:0]   sync1;
    logic [3:0]   sync2;
    logic [1:0]   prev;
    logic [W-1:0] shift;
    logic         sck_rise;
    logic         strobe_rise;
    logic         ce;
    logic         next_pd;
    logic [2:0]   mon_sel;
    logic [2:0]   mon_sync1;
    logic [2:0]   mon_sync2;

    // Rising edge of a synchronised pin against its level one clock earlier.
    function automatic logic rose_edge(input logic now_level, input logic last_level);
        return now_level & ~last_level;
    endfunction

    // Synchroniser first stage feeds only the second stage.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            prev  <= 2'h0;
        end
        else
        begin
            sync1 <= {chip_enable_i, load_strobe_i, serial_data_i, serial_clock_i};
            sync2 <= sync1;
            // A pin held high through reset shows one edge once released; hosts idle low.
            prev  <= {sync2[2], sync2[0]};
        end
    end

    // The monitor sources run on other clocks, so they pass two flip-flops as well.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mon_sync1 <= 3'h0;
            mon_sync2 <= 3'h0;
        end
        else
        begin
            mon_sync1 <= {lock_detect_i, rf_divided_i, ref_divided_i};
            mon_sync2 <= mon_sync1;
        end
    end

    assign sck_rise    = rose_edge(sync2[0], prev[0]);
    assign strobe_rise = rose_edge(sync2[2], prev[1]);
    assign ce          = sync2[3];

    // Data is sampled together with the clock edge, so it shares its sync delay.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            shift <= LATCH_RESET[W-1:0];
        else if (sck_rise)
            shift <= {shift[W-2:0], sync2[1]};
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            control_latch_o <= LATCH_RESET[W-1:0];
            refdiv_latch_o  <= LATCH_RESET[W-1:0];
            fbdiv_latch_o   <= LATCH_RESET[W-1:0];
            test_latch_o    <= LATCH_RESET[W-1:0];
        end
        else if (strobe_rise)
        begin
            case (shift[1:0])
                SEL_CONTROL: control_latch_o <= shift;
                SEL_REFDIV:  refdiv_latch_o  <= shift;
                SEL_FBDIV:   fbdiv_latch_o   <= shift;
                SEL_TEST:    test_latch_o    <= shift;
                default:     control_latch_o <= control_latch_o;
            endcase
        end
    end

    // Either stored power-down bit holds the core down even with enable high.
    assign next_pd = ~ce | control_latch_o[PD1_BIT] | control_latch_o[PD2_BIT];

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            powered_down_o             <= 1'b1;
            charge_pump_output_oe_o    <= 1'b0;
            ref_series_switch_closed_o <= 1'b0;
            ref_shunt_switch_o         <= 1'b1;
        end
        else
        begin
            powered_down_o             <= next_pd;
            charge_pump_output_oe_o    <= ce & ~next_pd;
            ref_series_switch_closed_o <= ~next_pd;
            ref_shunt_switch_o         <= next_pd;
        end
    end

    assign mon_sel = control_latch_o[MON_LSB+2:MON_LSB];

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            monitor_output_o <= 1'b0;
        else
        begin
            case (mon_sel)
                MON_LOCK:   monitor_output_o <= mon_sync2[2];
                MON_RFDIV:  monitor_output_o <= mon_sync2[1];
                MON_REFDIV: monitor_output_o <= mon_sync2[0];
                default:    monitor_output_o <= 1'b0;
            endcase
        end
    end

    // Each check except AST_REF_SW looks one clock after its cause, because every output is registered.
    // They are off during reset, when all outputs sit at their reset levels.
    AST_SHIFT_IN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sck_rise |=> shift[0] == $past(sync2[1]))
        else $error("shift register did not take data bit");

    AST_LOAD_SEL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (strobe_rise && shift[1:0] == SEL_FBDIV) |=> fbdiv_latch_o == $past(shift))
        else $error("feedback latch not loaded");

    AST_LOAD_CTRL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (strobe_rise && shift[1:0] == SEL_CONTROL) |=> control_latch_o == $past(shift)
            && $stable(refdiv_latch_o) && $stable(fbdiv_latch_o) && $stable(test_latch_o))
        else $error("control load touched another latch");

    AST_LOAD_REF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (strobe_rise && shift[1:0] == SEL_REFDIV) |=> refdiv_latch_o == $past(shift)
            && $stable(control_latch_o) && $stable(fbdiv_latch_o) && $stable(test_latch_o))
        else $error("reference divider load touched another latch");

    AST_NO_LOAD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !strobe_rise |=> $stable(control_latch_o) && $stable(refdiv_latch_o)
            && $stable(fbdiv_latch_o) && $stable(test_latch_o))
        else $error("latch changed without strobe");

    AST_CE_PD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !ce |=> powered_down_o)
        else $error("not powered down with enable low");

    AST_CE_CP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !ce |=> !charge_pump_output_oe_o)
        else $error("charge pump driven with enable low");

    AST_PD_BITS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce && !control_latch_o[PD1_BIT] && !control_latch_o[PD2_BIT]) |=> !powered_down_o)
        else $error("did not power up");

    AST_PD_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (control_latch_o[PD1_BIT] || control_latch_o[PD2_BIT]) |=> powered_down_o)
        else $error("stored power-down bit ignored");

    AST_REF_SW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ref_shunt_switch_o != ref_series_switch_closed_o)
        else $error("reference switches inconsistent");

    AST_CE_REF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !ce |=> ref_shunt_switch_o && !ref_series_switch_closed_o)
        else $error("reference pin still loaded with enable low");

    AST_MON: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        mon_sel == MON_LOCK |=> monitor_output_o == $past(mon_sync2[2]))
        else $error("monitor not lock detect");

    AST_MON_RF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        mon_sel == MON_RFDIV |=> monitor_output_o == $past(mon_sync2[1]))
        else $error("monitor not divided feedback");

    AST_MON_REF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        mon_sel == MON_REFDIV |=> monitor_output_o == $past(mon_sync2[0]))
        else $error("monitor not divided reference");

    AST_MON_OFF: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (mon_sel != MON_LOCK && mon_sel != MON_RFDIV && mon_sel != MON_REFDIV)
            |=> !monitor_output_o)
        else $error("monitor active with no source selected");
endmodule // sslp_port

// ===== sslp_host.sv
// Purpose: Host model that shifts words into the serial load port.
// Assumes: Serial clock period of 200 ns; the clock stands low between frames.
// Notes:   The data line shows the inverse of the last bit once a frame ends.
`timescale 1ns/10ps
module sslp_host (
    output logic sclk_o,
    output logic sdat_o,
    output logic strobe_o
);
    initial
    begin
        sclk_o = 1'b0;
        sdat_o = 1'b0;
        strobe_o = 1'b0;
    end
    task automatic send(input logic [23:0] w, input bit load);
        for (int i = 23; i >= 0; i--)
        begin
            sdat_o = w[i];
            #50 sclk_o = 1'b1;
            #100 sclk_o = 1'b0;
            #50;
        end
        // Nothing holds the data line after the frame, so it must not look stable.
        sdat_o = ~w[0];
        if (load)
        begin
            strobe_o = 1'b1;
            #200 strobe_o = 1'b0;
            #100;
        end
    endtask
endmodule // sslp_host

// ===== tb.sv
// Purpose: Self-checking bench for the serial load port.
// Assumes: Latch update lands 3 clocks after strobe; power status 3 clocks after enable.
// Notes:   The factory test latch is never written, as a real host would not.
`timescale 1ns/10ps
module tb;
    import sslp_pkg::*;
    logic clk, rst_n, ce, lock, rfd, refd, sclk, sdat, stb, pd, oe, ser, sh, mon;
    logic [23:0] cl, rl, fl, tl;
    int err_count = 0, total_checks = 0;
    sslp_host host (.sclk_o(sclk), .sdat_o(sdat), .strobe_o(stb));
    sslp_port uut (.clk_i(clk), .rst_n_i(rst_n), .serial_clock_i(sclk),
        .serial_data_i(sdat), .load_strobe_i(stb), .chip_enable_i(ce),
        .lock_detect_i(lock), .rf_divided_i(rfd), .ref_divided_i(refd),
        .control_latch_o(cl), .refdiv_latch_o(rl), .fbdiv_latch_o(fl), .test_latch_o(tl),
        .powered_down_o(pd), .charge_pump_output_oe_o(oe),
        .ref_series_switch_closed_o(ser), .ref_shunt_switch_o(sh), .monitor_output_o(mon));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic t_load;
        host.send(24'h123455, 1'b1);
        host.send(24'h000020, 1'b1);
        host.send(24'hABCDE6, 1'b1);
        cyc(4);
        chk(rl, 24'h123455);
        chk(cl, 24'h000020);
        chk(fl, 24'hABCDE6);
        chk(tl, LATCH_RESET);
        $display("load test done");
    endtask
    task automatic t_noload;
        host.send(24'h5A5A54, 1'b0);
        cyc(6);
        chk({cl[11:0], rl[11:0]}, 24'h020455);
        chk(fl, 24'hABCDE6);
        chk(tl, LATCH_RESET);
        $display("no-load test done");
    endtask
    task automatic t_power;
        chk({20'h0, pd, oe, ser, sh}, 24'h6);
        ce = 1'b0;
        cyc(4);
        chk({20'h0, pd, oe, ser, sh}, 24'h9);
        host.send(24'h100020, 1'b1);
        ce = 1'b1;
        cyc(4);
        chk({20'h0, pd, oe, ser, sh}, 24'h9);
        host.send(24'h200020, 1'b1);
        cyc(4);
        chk({20'h0, pd, oe, ser, sh}, 24'h9);
        host.send(24'h000020, 1'b1);
        cyc(4);
        chk({20'h0, pd, oe, ser, sh}, 24'h6);
        $display("power test done");
    endtask
    task automatic t_monitor;
        logic [2:0] code [3] = '{MON_LOCK, MON_RFDIV, MON_REFDIV};
        for (int k = 0; k < 3; k++)
        begin
            host.send(24'(code[k]) << MON_LSB, 1'b1);
            cyc(4);
            {lock, rfd, refd} = 3'(4 >> k);
            cyc(4);
            chk({23'h0, mon}, 24'h1);
            {lock, rfd, refd} = ~3'(4 >> k);
            cyc(4);
            chk({23'h0, mon}, 24'h0);
        end
        host.send(24'h000000, 1'b1);
        {lock, rfd, refd} = 3'h7;
        cyc(4);
        chk({23'h0, mon}, 24'h0);
        $display("monitor test done");
    endtask
    task automatic t_reset;
        rst_n = 1'b0;
        cyc(1);
        chk(cl, LATCH_RESET);
        chk(fl, LATCH_RESET);
        chk({20'h0, pd, oe, ser, sh}, 24'h9);
        rst_n = 1'b1;
        cyc(4);
        chk({20'h0, pd, oe, ser, sh}, 24'h6);
        chk({23'h0, mon}, 24'h0);
        $display("reset test done");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        {rst_n, ce, lock, rfd, refd} = 5'h08;
        cyc(10);
        rst_n = 1'b1;
        cyc(2);
        t_load();
        t_noload();
        t_power();
        t_monitor();
        t_reset();
        conclude();
    end
endmodule // tb
